// file: dv/pccr_host_model.sv
// Station management host model that writes and reads the control register pair.
`timescale 1ns/100ps
module pccr_host_model
  import pccr_pkg::*;
(
  input  wire logic                    clock_i,  // System clock.
  output pccr_pkg::pccr_addr_type      addr_o,   // Register address.
  output logic                         wr_o,     // Write strobe.
  output pccr_pkg::pccr_word_type      wdata_o,  // Write data.
  input  wire pccr_pkg::pccr_word_type rdata_i   // Registered read data.
);
  import pccr_pkg::*;

  // The bus is quiet until the first request.
  initial
  begin
    addr_o  = 5'h00;
    wr_o    = 1'b0;
    wdata_o = 16'h0000;
  end

  // One write, with the strobe high across exactly one rising edge.
  task automatic wr(input pccr_addr_type a, input pccr_word_type d);
    @(negedge clock_i);
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(negedge clock_i);
    wr_o    = 1'b0;
    // Data is no longer qualified, so show the inverse rather than a stale copy.
    wdata_o = ~d;
  endtask

  // One read; the word is registered on the edge that samples the address.
  task automatic rd(input pccr_addr_type a, output pccr_word_type d);
    @(negedge clock_i);
    addr_o = a;
    @(negedge clock_i);
    d = rdata_i;
  endtask
endmodule // pccr_host_model

// file: dv/tb.sv
// Self-checking testbench for the control register pair and its effects.
`timescale 1ns/100ps
module tb;
  import pccr_pkg::*;
  logic          clock_i, rst_i, link_up, an_f100, prt_f100, std_fdx;  // Clock, reset and status levels.
  logic          sym_en, nib_en, tx_en;                               // Symbol and nibble strobes, transmit enable.
  pccr_sym_type  sym;                                                 // Received code group.
  pccr_addr_type addr;                                                // Register address from the host.
  logic          wr;                                                  // Write strobe from the host.
  pccr_word_type wdata, rd_v;                                         // Write data and last read word.
  logic [15:0]   rdata;                                               // Read data from the block.
  logic          diag, robust, fdx, dv, rer, ierr, txen_o, txer_o;    // Block outputs.
  logic [4:0]    seen;                                                // Sticky record of pulses.
  int            fails, check_count;                                  // Report counters.

  pccr_host_model host (.clock_i(clock_i), .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rdata_i(rdata));
  pccr_top dut (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .link_up_i(link_up), .an_or_force100_i(an_f100), .partner_forced100_i(prt_f100),
    .std_full_duplex_i(std_fdx), .rx_sym_en_i(sym_en), .rx_sym_i(sym), .tx_nib_en_i(nib_en),
    .tx_en_i(tx_en), .tx_er_i(1'b0), .diag_start_o(diag), .robust_crossover_enable_o(robust),
    .full_duplex_o(fdx), .rx_dv_o(dv), .rx_er_o(rer), .idle_sym_err_o(ierr), .tx_en_o(txen_o),
    .tx_er_o(txer_o));

  ////////////////////////////////////////////////////////////////////////////
  // The clock runs at 125 MHz.
  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // One-cycle pulses are caught at every rising edge so that no check races them.
  always @(posedge clock_i)
  begin
    seen <= seen | {diag, rer, ierr, txer_o, dv};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  task automatic clr;
    @(negedge clock_i);
    seen = 5'h00;
  endtask

  // One code group, strobe high for one edge.
  task automatic send_sym(input pccr_sym_type s);
    @(negedge clock_i);
    sym    = s;
    sym_en = 1'b1;
    @(negedge clock_i);
    sym_en = 1'b0;
  endtask

  // One transmit nibble, strobe high for one edge; the task returns as the strobe drops.
  task automatic send_nib(input logic e);
    @(negedge clock_i);
    tx_en  = e;
    nib_en = 1'b1;
    @(negedge clock_i);
    nib_en = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_regs;
    host.rd(5'h09, rd_v);
    chk(rd_v, 16'h0000);
    host.rd(5'h0A, rd_v);
    chk(rd_v, 16'h0000);
    host.wr(5'h09, 16'hFFFF);
    host.rd(5'h09, rd_v);
    chk(rd_v, 16'h0122);
    cyc(1);
    chk(robust, 1'b1);
    host.wr(5'h0A, 16'hFFFF);
    host.rd(5'h0A, rd_v);
    chk(rd_v, 16'h0026);
    // An unmapped place takes nothing and reads back zero.
    host.wr(5'h0B, 16'hFFFF);
    host.rd(5'h0B, rd_v);
    chk(rd_v, 16'h0000);
    host.wr(5'h09, 16'h0000);
    host.wr(5'h0A, 16'h0000);
    cyc(2);
    chk(robust, 1'b0);
  endtask

  task automatic t_rx;
    // Normal mode: valid only once the K follows the J.
    send_sym(5'h18);
    cyc(2);
    chk(dv, 1'b0);
    send_sym(5'h11);
    cyc(2);
    chk(dv, 1'b1);
    send_sym(5'h1F);
    cyc(2);
    chk(dv, 1'b0);
    // Normal mode: a J without its K raises neither valid nor error.
    clr;
    send_sym(5'h18);
    send_sym(5'h05);
    cyc(2);
    chk(seen[3], 1'b0);
    chk(seen[0], 1'b0);
    // Early mode: valid on the J, error when the K is missing.
    host.wr(5'h09, 16'h0002);
    send_sym(5'h18);
    cyc(2);
    chk(dv, 1'b1);
    clr;
    send_sym(5'h05);
    cyc(2);
    chk(seen[3], 1'b1);
    chk(dv, 1'b0);
    send_sym(5'h1F);
    host.wr(5'h09, 16'h0000);
  endtask

  task automatic t_idle;
    for (int b = 1; b >= 0; b--)
    begin
      host.wr(5'h0A, 16'(b << 2));
      clr;
      send_sym(5'h05);
      cyc(2);
      chk(seen[2], b[0]);
    end
  endtask

  // Extended duplex needs all three conditions; otherwise the standard result stands.
  task automatic t_dup;
    an_f100  = 1'b1;
    prt_f100 = 1'b1;
    host.wr(5'h0A, 16'h0020);
    cyc(10);
    chk(fdx, 1'b1);
    prt_f100 = 1'b0;
    cyc(10);
    chk(fdx, 1'b0);
    prt_f100 = 1'b1;
    an_f100  = 1'b0;
    cyc(10);
    chk(fdx, 1'b0);
    an_f100  = 1'b1;
    host.wr(5'h0A, 16'h0000);
    cyc(10);
    chk(fdx, 1'b0);
    std_fdx = 1'b1;
    cyc(10);
    chk(fdx, 1'b1);
    std_fdx = 1'b0;
  endtask

  task automatic t_diag;
    for (int b = 1; b >= 0; b--)
    begin
      host.wr(5'h09, 16'(b << 8));
      link_up = 1'b1;
      cyc(10);
      clr;
      link_up = 1'b0;
      cyc(10);
      chk(seen[4], b[0]);
    end
  endtask

  // Odd frame length with and without the disable bit, then an even one.
  task automatic t_tx;
    for (int k = 0; k < 3; k++)
    begin
      host.wr(5'h0A, (k == 1) ? 16'h0002 : 16'h0000);
      clr;
      repeat ((k == 2) ? 4 : 3) send_nib(1'b1);
      // The first nibble after the end is the stretched one while it stands.
      send_nib(1'b0);
      chk({txen_o, txer_o}, (k == 0) ? 16'h0003 : 16'h0000);
      repeat (2) send_nib(1'b0);
      chk(seen[1], k == 0);
      chk(txen_o, 1'b0);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: inputs at time zero, 16 cycles of reset, then the scenarios.
  initial
  begin
    rst_i = 1'b1;
    {link_up, an_f100, prt_f100, std_fdx, sym_en, nib_en, tx_en} = 7'h00;
    sym = 5'h1F;
    seen = 5'h00;
    repeat (16) @(posedge clock_i);
    @(negedge clock_i);
    rst_i = 1'b0;
    t_regs;
    t_rx;
    t_idle;
    t_dup;
    t_diag;
    t_tx;
    end_sim;
  end

  // The scenarios need well under a thousand cycles; a hang is cut short here.
  initial
  begin
    #100000;
    fails++;
    end_sim;
  end
endmodule // tb

// file: rtl/pccr_pkg.sv
// Types shared by the PHY control register block.
package pccr_pkg;
  typedef logic [15:0] pccr_word_type;   // One management register word.
  typedef logic [4:0]  pccr_addr_type;   // Register address on the management bus.
  typedef logic [4:0]  pccr_sym_type;    // One received code group.
  typedef enum logic [1:0] {PCCR_RX_IDLE, PCCR_RX_GOT_J, PCCR_RX_DATA} pccr_rx_state_type;
endpackage

// file: rtl/pccr_regs.svh
// Register offsets, field positions, reset values and codes for the PHY control registers.
`ifndef PCCR_REGS_SVH
`define PCCR_REGS_SVH
`define PCCR_OFF_CABLE_RX     5'h09
`define PCCR_OFF_DUPLEX_ERR   5'h0A
`define PCCR_RESET_VALUE      16'h0000
`define PCCR_BIT_AUTORUN      8
`define PCCR_BIT_ROBUST       5
`define PCCR_BIT_EARLY_RXDV   1
`define PCCR_BIT_EXT_FDX      5
`define PCCR_BIT_IDLE_ERR     2
`define PCCR_BIT_ODD_DIS      1
`define PCCR_MASK_CABLE_RX    16'h0122
`define PCCR_MASK_DUPLEX_ERR  16'h0026
`define PCCR_SYM_J            5'h18
`define PCCR_SYM_K            5'h11
`define PCCR_SYM_IDLE         5'h1F
`endif

// file: rtl/pccr_top.sv
// Control register pair with its receive, duplex, crossover and diagnostic effects.
`timescale 1ns/100ps
`include "pccr_regs.svh"
module pccr_top
  import pccr_pkg::*;
(
  input  wire logic               clock_i,      // System clock, 125 MHz.
  input  wire logic               rst_i,        // Asynchronous reset, active high.
  input  wire pccr_pkg::pccr_addr_type reg_addr_i,   // Management register address.
  input  wire logic               reg_wr_i,     // Write strobe, one cycle.
  input  wire pccr_pkg::pccr_word_type reg_wdata_i,  // Write data.
  output logic [15:0]             reg_rdata_o,  // Registered read data for reg_addr_i.
  input  wire logic               link_up_i,    // Link status from the PCS.
  input  wire logic               an_or_force100_i, // Local side in autoneg or forced 100.
  input  wire logic               partner_forced100_i, // Partner detected as forced 100.
  input  wire logic               std_full_duplex_i,   // Standard duplex resolution.
  input  wire logic               rx_sym_en_i,  // One pulse per received code group.
  input  wire pccr_pkg::pccr_sym_type rx_sym_i, // Received code group.
  input  wire logic               tx_nib_en_i,  // One pulse per transmit nibble.
  input  wire logic               tx_en_i,      // Transmit enable from the MAC.
  input  wire logic               tx_er_i,      // Transmit error from the MAC.
  output logic                    diag_start_o, // One-cycle start of cable_reflectometry_diag.
  output logic                    robust_crossover_enable_o, // Robust crossover mode select.
  output logic                    full_duplex_o,// Resolved duplex.
  output logic                    rx_dv_o,      // Receive data valid.
  output logic                    rx_er_o,      // Receive error.
  output logic                    idle_sym_err_o, // Pulse: symbol error in idle.
  output logic                    tx_en_o,      // Transmit enable toward PCS.
  output logic                    tx_er_o       // Transmit error toward PCS.
);
  import pccr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.
  pccr_word_type cr1_q, cr1_d;      // cable_and_receive_control.
  pccr_word_type cr2_q, cr2_d;      // duplex_and_error_control.
  logic [15:0]   rdata_q, rdata_d;

  // Read decode is used for the read mux; a function keeps it in one place.
  function automatic pccr_word_type read_word(pccr_addr_type a, pccr_word_type c1, pccr_word_type c2);
    pccr_word_type w;
    w = 16'h0000;
    if (a == `PCCR_OFF_CABLE_RX)
      w = c1 & `PCCR_MASK_CABLE_RX;
    else if (a == `PCCR_OFF_DUPLEX_ERR)
      w = c2 & `PCCR_MASK_DUPLEX_ERR;
    return w;
  endfunction

  // Writes land only on writable fields; reserved bits stay zero.
  always_comb
  begin
    cr1_d = cr1_q;
    cr2_d = cr2_q;
    if (reg_wr_i && reg_addr_i == `PCCR_OFF_CABLE_RX)
      cr1_d = reg_wdata_i & `PCCR_MASK_CABLE_RX;
    else if (reg_wr_i && reg_addr_i == `PCCR_OFF_DUPLEX_ERR)
      cr2_d = reg_wdata_i & `PCCR_MASK_DUPLEX_ERR;
    rdata_d = read_word(reg_addr_i, cr1_d, cr2_d);
  end

  // Register flops; all fields clear on reset.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cr1_q   <= `PCCR_RESET_VALUE;
      cr2_q   <= `PCCR_RESET_VALUE;
      rdata_q <= `PCCR_RESET_VALUE;
    end
    else
    begin
      cr1_q   <= cr1_d;
      cr2_q   <= cr2_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link status and mode controls. Link and mode inputs come from pins or
  // another domain, so they pass three flops; a change counts when the last two agree.
  logic [3:0] s1_q, s2_q, s3_q, flt_q, flt_d;
  logic [3:0] raw;
  logic       diag_q, diag_d, rob_q, rob_d, fdx_q, fdx_d;
  assign raw = {std_full_duplex_i, partner_forced100_i, an_or_force100_i, link_up_i};

  // Synchroniser banks are whole vectors so that each bank has a single writing process.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Agreement filter per input; a level counts only once the last two flops match.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_sync
      assign flt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : flt_q[gi];
    end
  endgenerate

  // Diagnostic start on falling link, crossover mode, duplex resolution.
  always_comb
  begin
    diag_d = flt_q[0] && !flt_d[0] && cr1_q[`PCCR_BIT_AUTORUN];
    rob_d  = cr1_q[`PCCR_BIT_ROBUST];
    fdx_d  = flt_q[3];
    if (cr2_q[`PCCR_BIT_EXT_FDX] && flt_q[1] && flt_q[2])
      fdx_d = 1'b1;
  end

  // Control output flops.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      flt_q  <= 4'h0;
      diag_q <= 1'b0;
      rob_q  <= 1'b0;
      fdx_q  <= 1'b0;
    end
    else
    begin
      flt_q  <= flt_d;
      diag_q <= diag_d;
      rob_q  <= rob_d;
      fdx_q  <= fdx_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive start-of-stream detection. Simplified: any code group other than
  // idle inside a frame counts as data; the end of stream is idle.
  pccr_rx_state_type st_q, st_d;
  logic dv_q, dv_d, er_q, er_d, ise_q, ise_d;

  // Next state and receive flags.
  always_comb
  begin
    st_d  = st_q;
    dv_d  = dv_q;
    er_d  = 1'b0;
    ise_d = 1'b0;
    if (rx_sym_en_i)
    begin
      case (st_q)
        PCCR_RX_IDLE:
        begin
          dv_d = 1'b0;
          if (rx_sym_i == `PCCR_SYM_J)
          begin
            st_d = PCCR_RX_GOT_J;
            dv_d = cr1_q[`PCCR_BIT_EARLY_RXDV];
          end
          else if (rx_sym_i != `PCCR_SYM_IDLE && cr2_q[`PCCR_BIT_IDLE_ERR])
            ise_d = 1'b1;
        end
        PCCR_RX_GOT_J:
        begin
          if (rx_sym_i == `PCCR_SYM_K)
          begin
            st_d = PCCR_RX_DATA;
            dv_d = 1'b1;
          end
          else
          begin
            st_d = PCCR_RX_IDLE;
            er_d = cr1_q[`PCCR_BIT_EARLY_RXDV];
            dv_d = 1'b0;
          end
        end
        default:
        begin
          if (rx_sym_i == `PCCR_SYM_IDLE)
          begin
            st_d = PCCR_RX_IDLE;
            dv_d = 1'b0;
          end
        end
      endcase
    end
  end

  // Receive flops.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q  <= PCCR_RX_IDLE;
      dv_q  <= 1'b0;
      er_q  <= 1'b0;
      ise_q <= 1'b0;
    end
    else
    begin
      st_q  <= st_d;
      dv_q  <= dv_d;
      er_q  <= er_d;
      ise_q <= ise_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit odd-nibble handling.
  pccr_tx_odd u_tx_odd (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .tx_nib_en_i (tx_nib_en_i),
    .tx_en_i     (tx_en_i),
    .tx_er_i     (tx_er_i),
    .odd_dis_i   (cr2_q[`PCCR_BIT_ODD_DIS]),
    .tx_en_o     (tx_en_o),
    .tx_er_o     (tx_er_o)
  );

  assign reg_rdata_o               = rdata_q;
  assign diag_start_o              = diag_q;
  assign robust_crossover_enable_o = rob_q;
  assign full_duplex_o             = fdx_q;
  assign rx_dv_o                   = dv_q;
  assign rx_er_o                   = er_q;
  assign idle_sym_err_o            = ise_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_no_autorun_when_off;
    @(posedge clock_i) disable iff (rst_i)
      !cr1_q[`PCCR_BIT_AUTORUN] |=> !diag_start_o;
  endproperty
  a_no_autorun_when_off: assert property (p_no_autorun_when_off)
    else $error("Diagnostic started with auto-run off.");

  property p_robust_follows;
    @(posedge clock_i) disable iff (rst_i)
      ##1 robust_crossover_enable_o == $past(cr1_q[`PCCR_BIT_ROBUST]);
  endproperty
  a_robust_follows: assert property (p_robust_follows)
    else $error("Crossover mode does not follow its control bit.");

  property p_normal_dv_waits_k;
    @(posedge clock_i) disable iff (rst_i)
      (st_q == PCCR_RX_IDLE && rx_sym_en_i && !cr1_q[`PCCR_BIT_EARLY_RXDV]) |=> !rx_dv_o;
  endproperty
  a_normal_dv_waits_k: assert property (p_normal_dv_waits_k)
    else $error("Receive valid raised before K in normal mode.");

  property p_early_dv_on_j;
    @(posedge clock_i) disable iff (rst_i)
      (st_q == PCCR_RX_IDLE && rx_sym_en_i && rx_sym_i == `PCCR_SYM_J && cr1_q[`PCCR_BIT_EARLY_RXDV]) |=> rx_dv_o;
  endproperty
  a_early_dv_on_j: assert property (p_early_dv_on_j)
    else $error("Early receive valid missing on J.");

  property p_ext_fdx;
    @(posedge clock_i) disable iff (rst_i)
      (cr2_q[`PCCR_BIT_EXT_FDX] && flt_q[1] && flt_q[2]) |=> full_duplex_o;
  endproperty
  a_ext_fdx: assert property (p_ext_fdx)
    else $error("Extended full duplex not applied.");

  property p_idle_err_off;
    @(posedge clock_i) disable iff (rst_i)
      !cr2_q[`PCCR_BIT_IDLE_ERR] |=> !idle_sym_err_o;
  endproperty
  a_idle_err_off: assert property (p_idle_err_off)
    else $error("Idle symbol error reported while disabled.");

  property p_reserved_zero;
    @(posedge clock_i) disable iff (rst_i)
      ((cr1_q & ~`PCCR_MASK_CABLE_RX) == 16'h0000) && ((cr2_q & ~`PCCR_MASK_DUPLEX_ERR) == 16'h0000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved register bit became set.");
endmodule // pccr_top

// file: rtl/pccr_tx_odd.sv
// Transmit enable stretcher for frames ending on an odd nibble.
`timescale 1ns/100ps
`include "pccr_regs.svh"
module pccr_tx_odd
  import pccr_pkg::*;
(
  input  wire logic clock_i,        // System clock.
  input  wire logic rst_i,          // Asynchronous reset, active high.
  input  wire logic tx_nib_en_i,    // One-cycle pulse per transmit nibble clock.
  input  wire logic tx_en_i,        // Transmit enable from the MAC.
  input  wire logic tx_er_i,        // Transmit error from the MAC.
  input  wire logic odd_dis_i,      // Odd-nibble detection disable.
  output logic      tx_en_o,        // Transmit enable toward the PCS.
  output logic      tx_er_o         // Transmit error toward the PCS.
);
  import pccr_pkg::*;

  logic odd_q, odd_d;               // High after an odd count of nibbles in the frame.
  logic ext_q, ext_d;               // High during the stretched nibble.
  logic en_q, en_d;
  logic er_q, er_d;

  // The stretch lasts exactly one nibble period so byte alignment is restored.
  always_comb
  begin
    odd_d = odd_q;
    ext_d = ext_q;
    en_d  = en_q;
    er_d  = er_q;
    if (tx_nib_en_i)
    begin
      ext_d = 1'b0;
      if (tx_en_i)
      begin
        odd_d = ~odd_q;
        en_d  = 1'b1;
        er_d  = tx_er_i;
      end
      else if (odd_q && !odd_dis_i && !ext_q)
      begin
        ext_d = 1'b1;
        odd_d = 1'b0;
        en_d  = 1'b1;
        er_d  = 1'b1;
      end
      else
      begin
        odd_d = 1'b0;
        en_d  = 1'b0;
        er_d  = 1'b0;
      end
    end
  end

  // State registers only.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      odd_q <= 1'b0;
      ext_q <= 1'b0;
      en_q  <= 1'b0;
      er_q  <= 1'b0;
    end
    else
    begin
      odd_q <= odd_d;
      ext_q <= ext_d;
      en_q  <= en_d;
      er_q  <= er_d;
    end
  end

  assign tx_en_o = en_q;
  assign tx_er_o = er_q;

  // Disabled detection never produces a stretched nibble.
  property p_no_stretch_when_disabled;
    @(posedge clock_i) disable iff (rst_i)
      (tx_nib_en_i && !tx_en_i && odd_dis_i) |=> !tx_en_o;
  endproperty
  a_no_stretch_when_disabled: assert property (p_no_stretch_when_disabled)
    else $error("Transmit enable stretched while odd detection disabled.");

  // An odd end with detection on yields one enabled nibble flagged as error.
  property p_odd_stretch;
    @(posedge clock_i) disable iff (rst_i)
      (tx_nib_en_i && !tx_en_i && odd_q && !ext_q && !odd_dis_i) |=> (tx_en_o && tx_er_o);
  endproperty
  a_odd_stretch: assert property (p_odd_stretch)
    else $error("Odd nibble end was not stretched with error.");
endmodule // pccr_tx_odd
